//--- core/gpmc_regs.svh
// Timing counts and constants for the power-mode controller
`ifndef GPMC_REGS_SVH
`define GPMC_REGS_SVH
`define GPMC_CLK_PERIOD_NS     4
`define GPMC_OCV_TIME_NS       400
`define GPMC_OCV_CYC           ((`GPMC_OCV_TIME_NS + `GPMC_CLK_PERIOD_NS - 1) / `GPMC_CLK_PERIOD_NS)
`define GPMC_CAL_TIME_NS       200
`define GPMC_CAL_CYC           ((`GPMC_CAL_TIME_NS + `GPMC_CLK_PERIOD_NS - 1) / `GPMC_CLK_PERIOD_NS)
`define GPMC_SAMPLE_TIME_NS    1000
`define GPMC_SAMPLE_CYC        (`GPMC_SAMPLE_TIME_NS / `GPMC_CLK_PERIOD_NS)
`define GPMC_SAMPLE_LEN_CYC    4
`define GPMC_CFG_SLEEP_BIT     0
`define GPMC_SOC_ZERO          8'h00
`define GPMC_CNT_W             8
`endif

//--- core/gpmc_pkg.sv
// Types for the power-mode controller
package gpmc_pkg;
  typedef enum logic [2:0] {
    GPMC_INSERT_CHECK,
    GPMC_INIT,
    GPMC_NORMAL,
    GPMC_CALIB,
    GPMC_SLEEP,
    GPMC_SLEEP_PLUS,
    GPMC_HIBERNATE
  } gpmc_mode_t;

  // Measured values presented by the gauging side
  typedef struct packed {
    logic [15:0] avg_current;
    logic [15:0] cell_voltage;
    logic [15:0] remaining;
    logic        wake_current;
  } gpmc_meas_t;

  // Programmed thresholds
  typedef struct packed {
    logic [15:0] sleep_current;
    logic [15:0] hib_current;
    logic [15:0] hib_voltage;
    logic [15:0] term_voltage;
    logic [15:0] low_set;
    logic [15:0] low_clear;
  } gpmc_thr_t;
endpackage

//--- core/gpmc_sync.sv
// Two-flop synchroniser for one level input
`timescale 1ns/10ps
module gpmc_sync (
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // Level
  input  wire logic d,
  output logic      q
);
  logic s1_r;
  logic s1_nxt;
  logic q_nxt;

  always_comb begin
    s1_nxt = d;
    q_nxt  = s1_r;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      s1_r <= 1'b0;
      q    <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      q    <= q_nxt;
    end
  end
endmodule

//--- core/gpmc_timer.sv
// Loadable down-counter with a done flag
`timescale 1ns/10ps
`include "gpmc_regs.svh"
module gpmc_timer (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   nrst,
  // Control
  input  wire logic                   load,
  input  wire logic [`GPMC_CNT_W-1:0] value,
  // Status
  output logic                        done
);
  logic [`GPMC_CNT_W-1:0] cnt_r;
  logic [`GPMC_CNT_W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (load)
      cnt_nxt = value;
    else if (cnt_r != '0)
      cnt_nxt = cnt_r - 1'b1;
  end

  always_ff @(posedge clock) begin
    if (!nrst)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  // Read only in states that never load, so no path back through load
  assign done = (cnt_r == '0);
endmodule

//--- core/gpmc_core.sv
// Power-mode sequencer and low-charge flag of the gauge
`timescale 1ns/10ps
`include "gpmc_regs.svh"
module gpmc_core (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                nrst,
  // Pins from outside the clock domain
  input  wire logic                battery_in_pin,
  input  wire logic                ext_power_pin,
  input  wire logic                io_wake_pin,
  // Measurements and thresholds
  input  wire gpmc_pkg::gpmc_meas_t meas,
  input  wire gpmc_pkg::gpmc_thr_t  thr,
  input  wire logic [7:0]          soc_calc,
  // Configuration
  input  wire logic [7:0]          operation_config_word,
  input  wire logic                sleep_plus_enable,
  // Host command strobes
  input  wire logic                host_cmd,
  input  wire logic                host_addr_match,
  input  wire logic                host_hib_req,
  input  wire logic                host_sleep_req,
  // Status
  output gpmc_pkg::gpmc_mode_t     mode_r,
  output logic                     battery_present_flag,
  output logic                     low_charge_flag,
  output logic [7:0]               soc_report,
  output logic                     hf_osc_en,
  output logic                     lf_osc_en,
  output logic                     cpu_run,
  output logic                     gauge_run,
  output logic                     ocv_measure,
  output logic                     profile_select,
  output logic                     cc_calibrate,
  output logic                     cmd_served,
  output logic                     ocv_valid
);
  logic bat_s;
  logic pwr_s;
  logic iow_s;
  gpmc_sync u_sync_bat (.clock(clock), .nrst(nrst), .d(battery_in_pin),
                        .q(bat_s));
  gpmc_sync u_sync_pwr (.clock(clock), .nrst(nrst), .d(ext_power_pin),
                        .q(pwr_s));
  gpmc_sync u_sync_io  (.clock(clock), .nrst(nrst), .d(io_wake_pin),
                        .q(iow_s));

  gpmc_pkg::gpmc_mode_t mode_nxt;
  logic                 tmr_load;
  logic [`GPMC_CNT_W-1:0] tmr_val;
  logic                 tmr_done;
  gpmc_timer u_timer (.clock(clock), .nrst(nrst), .load(tmr_load),
                      .value(tmr_val), .done(tmr_done));

  // Periodic measurement tick for reduced-power modes
  logic [`GPMC_CNT_W-1:0] tick_r;
  logic [`GPMC_CNT_W-1:0] tick_nxt;
  logic                 hib_pend_r;
  logic                 hib_pend_nxt;
  logic                 ocv_valid_nxt;
  logic                 bpf_nxt;
  logic                 lcf_nxt;
  logic [7:0]           soc_nxt;
  logic                 hf_nxt;
  logic                 cpu_nxt;
  logic                 gauge_nxt;
  logic                 ocvm_nxt;
  logic                 prof_nxt;
  logic                 cal_nxt;
  logic                 served_nxt;

  logic avg_low;
  logic hib_cond;
  logic sleep_en;
  always_comb begin
    avg_low  = meas.avg_current < thr.sleep_current;
    sleep_en = operation_config_word[`GPMC_CFG_SLEEP_BIT];
    hib_cond = ocv_valid && ((meas.avg_current < thr.hib_current) ||
               (meas.cell_voltage < thr.hib_voltage));
  end

  always_comb begin
    mode_nxt     = mode_r;
    tmr_load     = 1'b0;
    tmr_val      = '0;
    hib_pend_nxt = hib_pend_r | host_hib_req;
    ocv_valid_nxt = ocv_valid;
    bpf_nxt      = battery_present_flag;
    served_nxt   = 1'b0;
    tick_nxt     = (tick_r == '0) ? `GPMC_CNT_W'(`GPMC_SAMPLE_CYC - 1)
                                  : tick_r - 1'b1;
    if (!bat_s && mode_r != gpmc_pkg::GPMC_INSERT_CHECK) begin
      // Removal under charger drops gauging at once
      mode_nxt      = gpmc_pkg::GPMC_INSERT_CHECK;
      bpf_nxt       = 1'b0;
      ocv_valid_nxt = 1'b0;
      hib_pend_nxt  = 1'b0;
    end else begin
      unique case (mode_r)
        gpmc_pkg::GPMC_INSERT_CHECK: begin
          served_nxt = host_cmd && host_addr_match && pwr_s;
          if (bat_s) begin
            mode_nxt = gpmc_pkg::GPMC_INIT;
            tmr_load = 1'b1;
            tmr_val  = `GPMC_CNT_W'(`GPMC_OCV_CYC);
          end
        end
        gpmc_pkg::GPMC_INIT: begin
          if (tmr_done) begin
            mode_nxt      = gpmc_pkg::GPMC_NORMAL;
            bpf_nxt       = 1'b1;
            ocv_valid_nxt = 1'b1;
          end
        end
        gpmc_pkg::GPMC_NORMAL: begin
          served_nxt = host_cmd && host_addr_match;
          if (hib_pend_r && hib_cond) begin
            mode_nxt = gpmc_pkg::GPMC_HIBERNATE;
          end else if (avg_low && !meas.wake_current &&
                       (sleep_plus_enable || sleep_en ||
                        host_sleep_req)) begin
            mode_nxt = gpmc_pkg::GPMC_CALIB;
            tmr_load = 1'b1;
            tmr_val  = `GPMC_CNT_W'(`GPMC_CAL_CYC);
          end
        end
        gpmc_pkg::GPMC_CALIB: begin
          if (!avg_low || meas.wake_current)
            mode_nxt = gpmc_pkg::GPMC_NORMAL;
          else if (tmr_done)
            mode_nxt = sleep_plus_enable ? gpmc_pkg::GPMC_SLEEP_PLUS
                                         : gpmc_pkg::GPMC_SLEEP;
        end
        gpmc_pkg::GPMC_SLEEP: begin
          if (!avg_low || meas.wake_current)
            mode_nxt = gpmc_pkg::GPMC_NORMAL;
        end
        gpmc_pkg::GPMC_SLEEP_PLUS: begin
          if (host_cmd || !avg_low || meas.wake_current)
            mode_nxt = gpmc_pkg::GPMC_NORMAL;
        end
        gpmc_pkg::GPMC_HIBERNATE: begin
          hib_pend_nxt = 1'b0;
          // Traffic for other targets must not wake it
          if ((host_cmd && host_addr_match) || iow_s) begin
            mode_nxt      = gpmc_pkg::GPMC_INIT;
            ocv_valid_nxt = 1'b0;
            tmr_load      = 1'b1;
            tmr_val       = `GPMC_CNT_W'(`GPMC_OCV_CYC);
          end
        end
        default: mode_nxt = gpmc_pkg::GPMC_INSERT_CHECK;
      endcase
    end
  end

  // HF oscillator and activity controls follow the next mode; lf_osc_en is held on out of reset
  always_comb begin
    hf_nxt    = !(mode_nxt == gpmc_pkg::GPMC_SLEEP ||
                  mode_nxt == gpmc_pkg::GPMC_HIBERNATE ||
                  mode_nxt == gpmc_pkg::GPMC_INSERT_CHECK);
    cpu_nxt   = (mode_nxt != gpmc_pkg::GPMC_INSERT_CHECK &&
                 mode_nxt != gpmc_pkg::GPMC_HIBERNATE) || served_nxt;
    ocvm_nxt  = (mode_nxt == gpmc_pkg::GPMC_INIT);
    prof_nxt  = (mode_r == gpmc_pkg::GPMC_INIT) &&
                (mode_nxt == gpmc_pkg::GPMC_NORMAL);
    cal_nxt   = (mode_nxt == gpmc_pkg::GPMC_CALIB);
    // Sleep modes measure only in a short window of each period
    unique case (mode_nxt)
      gpmc_pkg::GPMC_NORMAL, gpmc_pkg::GPMC_CALIB:
        gauge_nxt = 1'b1;
      gpmc_pkg::GPMC_SLEEP, gpmc_pkg::GPMC_SLEEP_PLUS:
        gauge_nxt = tick_r < `GPMC_CNT_W'(`GPMC_SAMPLE_LEN_CYC);
      default: gauge_nxt = 1'b0;
    endcase
  end

  // Low-charge hysteresis and termination clamp
  always_comb begin
    lcf_nxt = low_charge_flag;
    if (!battery_present_flag)
      lcf_nxt = 1'b0;
    else if (meas.remaining < thr.low_set)
      lcf_nxt = 1'b1;
    else if (meas.remaining > thr.low_clear)
      lcf_nxt = 1'b0;
    soc_nxt = soc_calc;
    if (meas.cell_voltage <= thr.term_voltage)
      soc_nxt = `GPMC_SOC_ZERO;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      mode_r               <= gpmc_pkg::GPMC_INSERT_CHECK;
      tick_r               <= '0;
      hib_pend_r           <= 1'b0;
      ocv_valid            <= 1'b0;
      battery_present_flag <= 1'b0;
      low_charge_flag      <= 1'b0;
      soc_report           <= 8'h00;
      hf_osc_en            <= 1'b0;
      lf_osc_en            <= 1'b0;
      cpu_run              <= 1'b0;
      gauge_run            <= 1'b0;
      ocv_measure          <= 1'b0;
      profile_select       <= 1'b0;
      cc_calibrate         <= 1'b0;
      cmd_served           <= 1'b0;
    end else begin
      mode_r               <= mode_nxt;
      tick_r               <= tick_nxt;
      hib_pend_r           <= hib_pend_nxt;
      ocv_valid            <= ocv_valid_nxt;
      battery_present_flag <= bpf_nxt;
      low_charge_flag      <= lcf_nxt;
      soc_report           <= soc_nxt;
      hf_osc_en            <= hf_nxt;
      lf_osc_en            <= 1'b1;
      cpu_run              <= cpu_nxt;
      gauge_run            <= gauge_nxt;
      ocv_measure          <= ocvm_nxt;
      profile_select       <= prof_nxt;
      cc_calibrate         <= cal_nxt;
      cmd_served           <= served_nxt;
    end
  end

  property p_remove;
    @(posedge clock) disable iff (!nrst)
    (!bat_s && mode_r != gpmc_pkg::GPMC_INSERT_CHECK) |=>
      mode_r == gpmc_pkg::GPMC_INSERT_CHECK && !battery_present_flag;
  endproperty
  a_remove: assert property (p_remove) else $error("no removal exit");

  property p_sleep_entry;
    @(posedge clock) disable iff (!nrst)
    $changed(mode_r) && mode_r == gpmc_pkg::GPMC_SLEEP |->
      $past(mode_r) == gpmc_pkg::GPMC_CALIB;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep without calibration");

  property p_sleep_hf;
    @(posedge clock) disable iff (!nrst)
    mode_r == gpmc_pkg::GPMC_SLEEP |-> !hf_osc_en;
  endproperty
  a_sleep_hf: assert property (p_sleep_hf) else $error("hf on in sleep");

  property p_plus_osc;
    @(posedge clock) disable iff (!nrst)
    mode_r == gpmc_pkg::GPMC_SLEEP_PLUS |-> hf_osc_en && lf_osc_en;
  endproperty
  a_plus_osc: assert property (p_plus_osc)
    else $error("osc off in sleep-plus");

  property p_wake;
    @(posedge clock) disable iff (!nrst)
    mode_r == gpmc_pkg::GPMC_SLEEP && bat_s && meas.wake_current |=>
      mode_r == gpmc_pkg::GPMC_NORMAL;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake exit");

  property p_low_flag;
    @(posedge clock) disable iff (!nrst)
    battery_present_flag && meas.remaining < thr.low_set |=> low_charge_flag;
  endproperty
  a_low_flag: assert property (p_low_flag) else $error("flag not set");

  property p_term;
    @(posedge clock) disable iff (!nrst)
    meas.cell_voltage <= thr.term_voltage |=> soc_report == 8'h00;
  endproperty
  a_term: assert property (p_term) else $error("soc not zero");

  property p_hib_stay;
    @(posedge clock) disable iff (!nrst)
    mode_r == gpmc_pkg::GPMC_HIBERNATE && bat_s && !iow_s &&
      !(host_cmd && host_addr_match) |=> mode_r == gpmc_pkg::GPMC_HIBERNATE;
  endproperty
  a_hib_stay: assert property (p_hib_stay) else $error("hib left");

  property p_init_done;
    @(posedge clock) disable iff (!nrst)
    $rose(mode_r == gpmc_pkg::GPMC_NORMAL) &&
      $past(mode_r) == gpmc_pkg::GPMC_INIT |-> battery_present_flag;
  endproperty
  a_init_done: assert property (p_init_done) else $error("no present");
endmodule

//--- dv/gpmc_host_model.sv
// Behavioural host processor that issues commands to the gauge
`timescale 1ns/10ps
module gpmc_host_model (
  // Clock
  input  wire logic clock,
  // Command strobes
  output logic      host_cmd,
  output logic      host_addr_match,
  output logic      host_hib_req,
  output logic      host_sleep_req
);
  initial begin
    host_cmd        = 1'b0;
    host_addr_match = 1'b0;
    host_hib_req    = 1'b0;
    host_sleep_req  = 1'b0;
  end

  // One-cycle command; location picking stays with the host
  task automatic send_cmd(input logic to_us);
    @(posedge clock);
    #1;
    host_cmd        = 1'b1;
    host_addr_match = to_us;
    @(posedge clock);
    #1;
    host_cmd        = 1'b0;
    host_addr_match = 1'b0;
  endtask

  // Hibernate needs the host to ask first
  task automatic req_hib();
    @(posedge clock);
    #1;
    host_hib_req = 1'b1;
    @(posedge clock);
    #1;
    host_hib_req = 1'b0;
  endtask

  // Host-started sleep, held as a level
  task automatic set_sleep(input logic v);
    host_sleep_req = v;
  endtask
endmodule

//--- dv/tb_top.sv
// Self-checking bench for the power-mode controller
`timescale 1ns/10ps
module tb_top;
  logic                 clock;
  logic                 nrst;
  logic                 battery_in;
  logic                 ext_power;
  logic                 io_wake;
  gpmc_pkg::gpmc_meas_t meas;
  gpmc_pkg::gpmc_thr_t  thr;
  logic [7:0]           soc_calc;
  logic [7:0]           opcfg;
  logic                 spe;
  logic                 host_cmd;
  logic                 host_addr_match;
  logic                 host_hib_req;
  logic                 host_sleep_req;
  gpmc_pkg::gpmc_mode_t mode;
  logic                 bat_flag;
  logic                 low_flag;
  logic [7:0]           soc_report;
  logic                 hf_osc_en;
  logic                 lf_osc_en;
  logic                 cpu_run;
  logic                 gauge_run;
  logic                 ocv_measure;
  logic                 profile_select;
  logic                 cc_calibrate;
  logic                 cmd_served;
  logic                 ocv_valid;
  logic                 seen_prof;
  logic                 seen_cal;
  logic                 seen_served;
  int                   fails;
  int                   comparisons;
  int                   cycles;
  int                   exp_low;
  int                   i;

  gpmc_core uut (
    .clock(clock), .nrst(nrst), .battery_in_pin(battery_in),
    .ext_power_pin(ext_power), .io_wake_pin(io_wake), .meas(meas),
    .thr(thr), .soc_calc(soc_calc), .operation_config_word(opcfg),
    .sleep_plus_enable(spe), .host_cmd(host_cmd),
    .host_addr_match(host_addr_match), .host_hib_req(host_hib_req),
    .host_sleep_req(host_sleep_req), .mode_r(mode),
    .battery_present_flag(bat_flag), .low_charge_flag(low_flag),
    .soc_report(soc_report), .hf_osc_en(hf_osc_en),
    .lf_osc_en(lf_osc_en), .cpu_run(cpu_run), .gauge_run(gauge_run),
    .ocv_measure(ocv_measure), .profile_select(profile_select),
    .cc_calibrate(cc_calibrate), .cmd_served(cmd_served),
    .ocv_valid(ocv_valid)
  );

  gpmc_host_model host (
    .clock(clock), .host_cmd(host_cmd),
    .host_addr_match(host_addr_match), .host_hib_req(host_hib_req),
    .host_sleep_req(host_sleep_req)
  );

  always #2 clock = ~clock;

  // Pulses end before the checks run, so keep a sticky copy
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (profile_select === 1'b1) seen_prof <= 1'b1;
    if (cc_calibrate === 1'b1) seen_cal <= 1'b1;
    if (cmd_served === 1'b1) seen_served <= 1'b1;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string n, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Bounded wait, then compare the mode
  task automatic wait_mode(input gpmc_pkg::gpmc_mode_t m, input int lim);
    for (int k = 0; k < lim && mode !== m; k++) step(1);
    check("mode_r", 16'(mode), 16'(m));
  endtask

  initial begin
    clock = 1'b0; nrst = 1'b0; battery_in = 1'b0; ext_power = 1'b1;
    io_wake = 1'b0; soc_calc = 8'h40; opcfg = 8'h00; spe = 1'b0;
    seen_prof = 1'b0; seen_cal = 1'b0; seen_served = 1'b0;
    fails = 0; comparisons = 0; cycles = 0; exp_low = 0;
    meas = '{16'h0800, 16'h0f00, 16'h0400, 1'b0};
    thr = '{16'h0100, 16'h0040, 16'h0c00, 16'h0d00, 16'h0200, 16'h0300};
    void'($urandom(32'hdadcac1f));
    // Syncs clear on the first reset edge
    step(3);
    nrst = 1'b1;
    step(1);
    check("mode_r", 16'(mode), 16'(gpmc_pkg::GPMC_INSERT_CHECK));
    check("battery_present_flag", 16'(bat_flag), 16'h0000);
    check("cpu_run", 16'(cpu_run), 16'h0000);
    host.send_cmd(1'b1);
    step(8);
    check("cmd_served", 16'(seen_served), 16'h0001);
    check("cpu_run", 16'(cpu_run), 16'h0000);
    check("mode_r", 16'(mode), 16'(gpmc_pkg::GPMC_INSERT_CHECK));
    // Without external power no command is serviced in GPMC_INSERT_CHECK
    ext_power = 1'b0;
    step(3);
    seen_served = 1'b0;
    host.send_cmd(1'b1);
    step(2);
    check("cmd_served", 16'(seen_served), 16'h0000);
    ext_power = 1'b1;
    step(3);
    battery_in = 1'b1;
    step(5);
    check("ocv_measure", 16'(ocv_measure), 16'h0001);
    wait_mode(gpmc_pkg::GPMC_NORMAL, 150);
    step(1);
    check("battery_present_flag", 16'(bat_flag), 16'h0001);
    check("profile_select", 16'(seen_prof), 16'h0001);
    check("gauge_run", 16'(gauge_run), 16'h0001);
    check("ocv_valid", 16'(ocv_valid), 16'h0001);
    for (i = 0; i < 24; i++) begin
      meas.remaining = 16'h0180 + 16'($urandom % 32'h200);
      meas.cell_voltage = 16'h0c80 + 16'($urandom % 32'h100);
      soc_calc = 8'($urandom);
      if (meas.remaining < thr.low_set) exp_low = 1;
      else if (meas.remaining > thr.low_clear) exp_low = 0;
      step(3);
      check("low_charge_flag", 16'(low_flag), 16'(exp_low));
      check("soc_report", 16'(soc_report),
            meas.cell_voltage <= thr.term_voltage ? 16'h0 : 16'(soc_calc));
    end
    meas.cell_voltage = 16'h0f00;
    meas.remaining = 16'h0400;
    // Low average alone must not start sleep
    meas.avg_current = 16'h0080;
    step(80);
    check("mode_r", 16'(mode), 16'(gpmc_pkg::GPMC_NORMAL));
    host.set_sleep(1'b1);
    wait_mode(gpmc_pkg::GPMC_SLEEP, 100);
    meas.avg_current = 16'h0800;
    host.set_sleep(1'b0);
    wait_mode(gpmc_pkg::GPMC_NORMAL, 10);
    seen_cal = 1'b0;
    opcfg = 8'h01;
    meas.avg_current = 16'h0080;
    wait_mode(gpmc_pkg::GPMC_CALIB, 10);
    check("cc_calibrate", 16'(cc_calibrate), 16'h0001);
    wait_mode(gpmc_pkg::GPMC_SLEEP, 80);
    check("hf_osc_en", 16'(hf_osc_en), 16'h0000);
    check("lf_osc_en", 16'(lf_osc_en), 16'h0001);
    meas.wake_current = 1'b1;
    wait_mode(gpmc_pkg::GPMC_NORMAL, 10);
    opcfg = 8'h00;
    meas.wake_current = 1'b0;
    seen_cal = 1'b0;
    spe = 1'b1;
    wait_mode(gpmc_pkg::GPMC_SLEEP_PLUS, 80);
    check("cc_calibrate", 16'(seen_cal), 16'h0001);
    check("hf_osc_en", 16'(hf_osc_en), 16'h0001);
    check("lf_osc_en", 16'(lf_osc_en), 16'h0001);
    host.send_cmd(1'b0);
    wait_mode(gpmc_pkg::GPMC_NORMAL, 10);
    spe = 1'b0;
    meas.avg_current = 16'h0800;
    wait_mode(gpmc_pkg::GPMC_NORMAL, 80);
    meas.avg_current = 16'h0010;
    host.req_hib();
    wait_mode(gpmc_pkg::GPMC_HIBERNATE, 100);
    check("cpu_run", 16'(cpu_run), 16'h0000);
    host.send_cmd(1'b0);
    step(20);
    check("mode_r", 16'(mode), 16'(gpmc_pkg::GPMC_HIBERNATE));
    host.send_cmd(1'b1);
    wait_mode(gpmc_pkg::GPMC_INIT, 10);
    meas.avg_current = 16'h0800;
    wait_mode(gpmc_pkg::GPMC_NORMAL, 150);
    // Second hibernate, woken by the input pin instead
    meas.avg_current = 16'h0010;
    host.req_hib();
    wait_mode(gpmc_pkg::GPMC_HIBERNATE, 100);
    io_wake = 1'b1;
    wait_mode(gpmc_pkg::GPMC_INIT, 10);
    io_wake = 1'b0;
    check("ocv_valid", 16'(ocv_valid), 16'h0000);
    meas.avg_current = 16'h0800;
    wait_mode(gpmc_pkg::GPMC_NORMAL, 150);
    check("ocv_valid", 16'(ocv_valid), 16'h0001);
    meas.remaining = 16'h0100;
    step(3);
    check("low_charge_flag", 16'(low_flag), 16'h0001);
    battery_in = 1'b0;
    wait_mode(gpmc_pkg::GPMC_INSERT_CHECK, 10);
    check("gauge_run", 16'(gauge_run), 16'h0000);
    check("battery_present_flag", 16'(bat_flag), 16'h0000);
    // Flag clear trails the present flag by one edge
    step(1);
    check("low_charge_flag", 16'(low_flag), 16'h0000);
    complete_run();
  end
endmodule
